// >>> design/btm14_defines.vh
// Register map, field positions and reset values of the 14-bit base timer
`ifndef BTM14_DEFINES_VH
`define BTM14_DEFINES_VH

// Register indices; byte address on the bus is four times the index
`define BTM14_IDX_INPUT_SIGNAL_SELECT 16'hfe5f
`define BTM14_IDX_BASE_TIMER_CONTROL  16'hfe7f
`define BTM14_IDX_COUNT_LOW           16'hfe7d
`define BTM14_IDX_COUNT_HIGH          16'hfe7e

// Reset values
`define BTM14_RST_INPUT_SIGNAL_SELECT 8'h00
`define BTM14_RST_BASE_TIMER_CONTROL  8'h00

// Control register fields
`define BTM14_CTL_INT0_ENABLE         0
`define BTM14_CTL_INT0_FLAG           1
`define BTM14_CTL_INT1_ENABLE         2
`define BTM14_CTL_INT1_FLAG           3
`define BTM14_CTL_INT1_SEL_LO         4
`define BTM14_CTL_INT1_SEL_HI         5
`define BTM14_CTL_RUN_CONTINUE        6
`define BTM14_CTL_INT0_SHORT          7

// Input signal select fields
`define BTM14_INSEL_BUZZER_ENABLE     3
`define BTM14_INSEL_CLK_SEL_LO        4
`define BTM14_INSEL_CLK_SEL_HI        5

// Clock source codes
`define BTM14_SRC_SUB_A               2'h0
`define BTM14_SRC_CYCLE               2'h1
`define BTM14_SRC_SUB_B               2'h2
`define BTM14_SRC_T0_PRESCALE         2'h3

// Counter terminal values and interrupt 1 period masks
`define BTM14_CNT8_MAX                8'hff
`define BTM14_CNT6_MAX                6'h3f
`define BTM14_CNT8_MASK_32            8'h1f
`define BTM14_CNT8_MASK_128           8'h7f
`define BTM14_CNT6_MASK_BIT0          6'h01
`define BTM14_CNT6_MASK_BIT2          6'h07

// Buzzer divide: input clock over sixteen
`define BTM14_BUZ_DIV_BITS            4

`endif

// >>> design/btm14_clk_sel.v
// Input clock source synchroniser, select and rising-edge tick generator
`include "btm14_defines.vh"

module btm14_clk_sel
(
  input  wire       clk,
  input  wire       rst_b,
  input  wire       subclock,
  input  wire       cycle_clock,
  input  wire       t0_prescale_out,
  input  wire [1:0] clock_source_sel,
  output wire       input_clock_tick
);

  reg  [2:0] meta_ff;
  reg  [2:0] sync_ff;
  reg        sel_dly_ff;
  reg        sel_lvl;

  // Two-stage synchronisers; first stage read only by second
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_ff <= 3'h0;
      sync_ff <= 3'h0;
    end
    else
    begin
      meta_ff <= {t0_prescale_out, cycle_clock, subclock};
      sync_ff <= meta_ff;
    end
  end

  // Source select on the synchronised levels
  always @*
  begin
    case (clock_source_sel)
      `BTM14_SRC_CYCLE:       sel_lvl = sync_ff[1];
      `BTM14_SRC_T0_PRESCALE: sel_lvl = sync_ff[2];
      default:                sel_lvl = sync_ff[0];
    endcase
  end

  // Delay for edge detect; a source switch may yield one stray tick
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      sel_dly_ff <= 1'b0;
    else
      sel_dly_ff <= sel_lvl;
  end

  assign input_clock_tick = sel_lvl & ~sel_dly_ff;

endmodule // btm14_clk_sel

// >>> design/btm14_buzzer.v
// Buzzer divider and port pin gating with the pwm high output
`include "btm14_defines.vh"

module btm14_buzzer
(
  input  wire clk,
  input  wire rst_b,
  input  wire input_clock_tick,
  input  wire buzzer_enable,
  input  wire pwm_high_output,
  output wire buzzer_port_pin
);

  reg  [`BTM14_BUZ_DIV_BITS-1:0] div_ff;
  reg                            pin_ff;

  // Free divider of input clock ticks; top bit is the divide by sixteen
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      div_ff <= {`BTM14_BUZ_DIV_BITS{1'b0}};
    else if (input_clock_tick)
      div_ff <= div_ff + {{(`BTM14_BUZ_DIV_BITS-1){1'b0}}, 1'b1};
  end

  // Held high when disabled, then ANDed with pwm before the pin
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      pin_ff <= 1'b1;
    else
      pin_ff <= (buzzer_enable ? div_ff[`BTM14_BUZ_DIV_BITS-1] : 1'b1)
                & pwm_high_output;
  end

  assign buzzer_port_pin = pin_ff;

endmodule // btm14_buzzer

// >>> design/btm14_base_timer.v
// Base timer top: bus slave, cascaded counters, interrupt flags, hold release
`include "btm14_defines.vh"

module btm14_base_timer
(
  input  wire        clk,
  input  wire        rst_b,
  input  wire [17:0] avs_address,
  input  wire [3:0]  avs_byteenable,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output wire [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire        subclock,
  input  wire        cycle_clock,
  input  wire        t0_prescale_out,
  input  wire        pwm_high_output,
  input  wire        hold_mode,
  input  wire        power_control_timer_hold,
  output wire        buzzer_port_pin,
  output wire        irq_base_timer,
  output wire        hold_release
);

  reg  [7:0]  ctl_ff;
  reg  [7:0]  nxt_ctl;
  reg  [7:0]  insel_ff;
  reg  [7:0]  cnt8_ff;
  reg  [7:0]  nxt_cnt8;
  reg  [5:0]  cnt6_ff;
  reg  [5:0]  nxt_cnt6;
  reg         ack_ff;
  reg  [31:0] rdata_ff;
  reg         irq_ff;
  reg  [7:0]  rd_byte;
  reg         int1_evt;
  reg  [5:0]  int1_mask6;

  wire        tick;
  wire        req;
  wire        wr_go;
  wire [15:0] word_idx;
  wire        addr_ok;
  wire        hit_ctl;
  wire        hit_insel;
  wire        hit_lo;
  wire        hit_hi;
  wire        wr_ctl;
  wire        wr_insel;
  wire        wr_clr8;
  wire        wr_clr6;
  wire [7:0]  wbyte;
  wire        short_mode;
  wire        run_cont;
  wire        at_zero;
  wire        hold_gate;
  wire        count_on;
  wire        inc8;
  wire        ovf8;
  wire        inc6;
  wire        ovf6;
  wire        int0_evt;
  wire        sel_change;
  wire        int1_spur;
  wire        int1_set;
  wire [1:0]  int1_sel;
  wire [1:0]  irq_term;
  genvar      gi;

  // Clock source select and tick generation
  btm14_clk_sel u_clk_sel
  (
    .clk              (clk),
    .rst_b            (rst_b),
    .subclock         (subclock),
    .cycle_clock      (cycle_clock),
    .t0_prescale_out  (t0_prescale_out),
    .clock_source_sel (insel_ff[`BTM14_INSEL_CLK_SEL_HI:`BTM14_INSEL_CLK_SEL_LO]),
    .input_clock_tick (tick)
  );

  // Buzzer keeps running off the tick, not gated by the counters
  btm14_buzzer u_buzzer
  (
    .clk              (clk),
    .rst_b            (rst_b),
    .input_clock_tick (tick),
    .buzzer_enable    (insel_ff[`BTM14_INSEL_BUZZER_ENABLE]),
    .pwm_high_output  (pwm_high_output),
    .buzzer_port_pin  (buzzer_port_pin)
  );

  // Bus slave: one wait cycle, answer on the second edge of a request
  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_ff;
  assign wr_go           = avs_write & ack_ff & avs_byteenable[0];

  // Word index and low byte lane; misaligned addresses hit nothing
  assign word_idx        = avs_address[17:2];
  assign addr_ok         = (avs_address[1:0] == 2'h0);
  assign wbyte           = avs_writedata[7:0];

  // Register hits, decoded once for the write strobes
  assign hit_ctl   = addr_ok & (word_idx == `BTM14_IDX_BASE_TIMER_CONTROL);
  assign hit_insel = addr_ok & (word_idx == `BTM14_IDX_INPUT_SIGNAL_SELECT);
  assign hit_lo    = addr_ok & (word_idx == `BTM14_IDX_COUNT_LOW);
  assign hit_hi    = addr_ok & (word_idx == `BTM14_IDX_COUNT_HIGH);

  // Write strobes; the count stages clear on a write of any value
  assign wr_ctl   = wr_go & hit_ctl;
  assign wr_insel = wr_go & hit_insel;
  assign wr_clr8  = wr_go & hit_lo;
  assign wr_clr6  = wr_go & hit_hi;

  // Ack lasts one cycle, so every request sees exactly one wait cycle
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ack_ff <= 1'b0;
    else
      ack_ff <= req & ~ack_ff;
  end

  // Read mux; unmapped addresses read as zero
  always @*
  begin
    rd_byte = 8'h00;
    if (addr_ok)
    begin
      case (word_idx)
        `BTM14_IDX_BASE_TIMER_CONTROL:  rd_byte = ctl_ff;
        `BTM14_IDX_INPUT_SIGNAL_SELECT: rd_byte = insel_ff;
        `BTM14_IDX_COUNT_LOW:           rd_byte = cnt8_ff;
        `BTM14_IDX_COUNT_HIGH:          rd_byte = {2'h0, cnt6_ff};
        default:                        rd_byte = 8'h00;
      endcase
    end
  end

  // Read data captured in the wait cycle, stands at the answering edge
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rdata_ff <= 32'h0000_0000;
    else if (avs_read & ~ack_ff)
      rdata_ff <= {24'h00_0000, rd_byte};
  end

  // Flopped read data, so the bus output never glitches
  assign avs_readdata = rdata_ff;

  // Input signal select: all bits stored, only clock and buzzer used here
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      insel_ff <= `BTM14_RST_INPUT_SIGNAL_SELECT;
    else if (wr_insel)
      insel_ff <= wbyte;
  end

  // Counting gate
  assign short_mode = ctl_ff[`BTM14_CTL_INT0_SHORT];
  assign run_cont   = ctl_ff[`BTM14_CTL_RUN_CONTINUE];
  assign int1_sel   = ctl_ff[`BTM14_CTL_INT1_SEL_HI:`BTM14_CTL_INT1_SEL_LO];
  assign at_zero    = (cnt8_ff == 8'h00) & (cnt6_ff == 6'h00);
  // Hold mode stops the timer unless the power control bit keeps it alive
  assign hold_gate  = ~hold_mode | power_control_timer_hold;
  assign count_on   = tick & hold_gate & (run_cont | ~at_zero);

  // Cascade: six-bit stage on tick in short mode, else on byte overflow
  assign inc8 = count_on;
  assign ovf8 = inc8 & (cnt8_ff == `BTM14_CNT8_MAX);
  assign inc6 = short_mode ? count_on : ovf8;
  assign ovf6 = inc6 & (cnt6_ff == `BTM14_CNT6_MAX);

  // Counter next values; a software write clears the addressed stage
  always @*
  begin
    nxt_cnt8 = cnt8_ff;
    nxt_cnt6 = cnt6_ff;
    if (inc8)
      nxt_cnt8 = cnt8_ff + 8'h01;
    if (inc6)
      nxt_cnt6 = cnt6_ff + 6'h01;
    if (wr_clr8)
      nxt_cnt8 = 8'h00;
    if (wr_clr6)
      nxt_cnt6 = 6'h00;
  end

  // Both stages load their next value on every edge
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt8_ff <= 8'h00;
      cnt6_ff <= 6'h00;
    end
    else
    begin
      cnt8_ff <= nxt_cnt8;
      cnt6_ff <= nxt_cnt6;
    end
  end

  // Interrupt 0: six-bit wrap gives 64 or 16384 input clocks
  assign int0_evt = ovf6;

  // Interrupt 1 period decode
  always @*
  begin
    int1_mask6 = `BTM14_CNT6_MASK_BIT0;
    int1_evt   = 1'b0;
    case ({short_mode, int1_sel})
      3'h0, 3'h4:
        int1_evt = inc8 & ((cnt8_ff & `BTM14_CNT8_MASK_32) == `BTM14_CNT8_MASK_32);
      3'h1, 3'h5:
        int1_evt = inc8 & ((cnt8_ff & `BTM14_CNT8_MASK_128) == `BTM14_CNT8_MASK_128);
      3'h2, 3'h6:
      begin
        int1_mask6 = `BTM14_CNT6_MASK_BIT0;
        int1_evt   = inc6 & ((cnt6_ff & int1_mask6) == int1_mask6);
      end
      3'h3, 3'h7:
      begin
        int1_mask6 = `BTM14_CNT6_MASK_BIT2;
        int1_evt   = inc6 & ((cnt6_ff & int1_mask6) == int1_mask6);
      end
      default:
        int1_evt = 1'b0;
    endcase
  end

  // Changing the interrupt 1 select while active raises the flag
  assign sel_change = wr_ctl &
    (wbyte[`BTM14_CTL_INT1_SEL_HI:`BTM14_CTL_INT1_SEL_LO] !=
     int1_sel);
  assign int1_spur  = sel_change & (run_cont | ~at_zero);
  assign int1_set   = int1_evt | int1_spur;

  // Control register; hardware set wins over a write in the same cycle
  always @*
  begin
    nxt_ctl = ctl_ff;
    if (wr_ctl)
      nxt_ctl = wbyte;
    if (int1_set)
      nxt_ctl[`BTM14_CTL_INT1_FLAG] = 1'b1;
    if (int0_evt)
      nxt_ctl[`BTM14_CTL_INT0_FLAG] = 1'b1;
  end

  // Control register flops
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ctl_ff <= `BTM14_RST_BASE_TIMER_CONTROL;
    else
      ctl_ff <= nxt_ctl;
  end

  // Per-interrupt request terms; each flag sits one bit above its enable
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_irq_term
      assign irq_term[gi] = ctl_ff[`BTM14_CTL_INT0_FLAG + 2*gi] &
                            ctl_ff[`BTM14_CTL_INT0_ENABLE + 2*gi];
    end
  endgenerate

  // Request and hold release share one registered level
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      irq_ff <= 1'b0;
    else
      irq_ff <= |irq_term;
  end

  // Hold release wakes the crystal hold state whenever a request stands
  assign irq_base_timer = irq_ff;
  assign hold_release   = irq_ff;

endmodule // btm14_base_timer

// >>> tb/btm14_checker.sv
// Checker of bus handshake, request and buzzer outputs of the base timer
module btm14_checker
(
  input wire        clk,
  input wire        rst_b,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        pwm_high_output,
  input wire        buzzer_port_pin,
  input wire        irq_base_timer,
  input wire        hold_release
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire       req = avs_read | avs_write;
  reg        wr_done_ff;
  reg  [1:0] live_ff;
  // Completed write one edge back; live_ff skips the pin's reset settling
  always @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      wr_done_ff <= 1'b0;
      live_ff    <= 2'h0;
    end
    else
    begin
      wr_done_ff <= avs_write & ~avs_waitrequest;
      live_ff    <= (live_ff == 2'h3) ? live_ff : live_ff + 2'h1;
    end
  a_wait_first: assert property ($rose(req) |-> avs_waitrequest)
    else $error("request answered without wait");
  a_wait_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait cycle");
  a_wait_idle: assert property (!req |-> !avs_waitrequest)
    else $error("wait raised while idle");
  a_rdata_stands: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
    else $error("read data moved without read");
  a_rdata_upper: assert property (avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_irq_release: assert property (irq_base_timer == hold_release)
    else $error("hold release differs from request");
  a_irq_fall_write: assert property ($fell(irq_base_timer) |-> $past(wr_done_ff))
    else $error("request dropped without write");
  a_buz_pwm_and:
    assert property (live_ff == 2'h3 && !$past(pwm_high_output) |-> !buzzer_port_pin)
    else $error("buzzer pin high while pwm low");
  c_irq_rise: cover property ($rose(irq_base_timer));
  c_buz_toggle: cover property ($changed(buzzer_port_pin) && pwm_high_output);
  c_read_done: cover property (avs_read && !avs_waitrequest);
endmodule // btm14_checker

bind btm14_base_timer btm14_checker u_btm14_checker
(
  .clk(clk), .rst_b(rst_b), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .pwm_high_output(pwm_high_output), .buzzer_port_pin(buzzer_port_pin),
  .irq_base_timer(irq_base_timer), .hold_release(hold_release)
);

// >>> tb/btm14_base_timer_tb.sv
// Self-checking bench of the base timer: bus, counts, periods, buzzer, hold
`include "btm14_defines.vh"
module btm14_base_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [15:0] ctl = `BTM14_IDX_BASE_TIMER_CONTROL;
  localparam [15:0] insel = `BTM14_IDX_INPUT_SIGNAL_SELECT;
  localparam [15:0] lo  = `BTM14_IDX_COUNT_LOW;
  localparam [15:0] hi  = `BTM14_IDX_COUNT_HIGH;
  reg         clk = 1'b0, rst_b = 1'b0, rd = 1'b0, wr = 1'b0;
  reg         pwm = 1'b1, hold = 1'b0, pwr = 1'b0, buz_q = 1'b1;
  reg  [2:0]  src = 3'h0, s;
  reg  [17:0] addr = 18'h0;
  reg  [31:0] wdata = 32'h0, q;
  reg  [15:0] lfsr = 16'h002b;
  reg  [22:0] r;
  wire [31:0] rdata;
  wire        wait_rq, buz, irq, hrel;
  integer     num_errors = 0, tests_run = 0, tog = 0, i, n, k;
  always #5 clk = ~clk;
  btm14_base_timer u_btm14_base_timer
  (
    .clk(clk), .rst_b(rst_b), .avs_address(addr), .avs_byteenable(4'hf), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wait_rq),
    .subclock(src[0]), .cycle_clock(src[1]), .t0_prescale_out(src[2]),
    .pwm_high_output(pwm), .hold_mode(hold), .power_control_timer_hold(pwr),
    .buzzer_port_pin(buz), .irq_base_timer(irq), .hold_release(hrel)
  );
  // Buzzer pin changes, counted once a cycle
  always @(posedge clk)
  begin
    buz_q <= buz;
    if (buz !== buz_q)
      tog <= tog + 1;
  end
  // Shift sequence with fixed start so runs repeat
  function [15:0] nxt_rand(input [15:0] v);
    nxt_rand = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // Source line each clock code listens to
  function [2:0] src_of(input [1:0] c);
    src_of = (c == 2'h1) ? 3'h2 : (c == 2'h3) ? 3'h4 : 3'h1;
  endfunction
  // Control value and expected interrupt period per row
  function [22:0] row(input integer j);
    case (j)
      0: row = {8'hc1, 15'h0040};
      1: row = {8'h44, 15'h0020};
      2: row = {8'h54, 15'h0080};
      3: row = {8'h64, 15'h0200};
      4: row = {8'h74, 15'h0800};
      5: row = {8'he4, 15'h0002};
      6: row = {8'hf4, 15'h0008};
      default: row = {8'h41, 15'h4000};
    endcase
  endfunction
  task chk(input [31:0] seen, input [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // One bus cycle, held until wait drops; a bound guards against a hang
  task bus(input w, input [15:0] idx, input [7:0] d);
    k = 0;
    addr <= {idx, 2'h0};
    wdata <= {24'h0, d};
    rd <= ~w;
    wr <= w;
    @(posedge clk);
    while (wait_rq !== 1'b0 && k < 20)
    begin
      @(posedge clk);
      k = k + 1;
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k == 20)
    begin
      chk(32'h0, 32'h1);
      give_verdict;
    end
    @(posedge clk);
  endtask
  task wreg(input [15:0] idx, input [7:0] d);
    bus(1'b1, idx, d);
  endtask
  task rchk(input [15:0] idx, input [31:0] e);
    bus(1'b0, idx, 8'h00);
    chk(q, e);
  endtask
  task clr;
    wreg(lo, 8'h00);
    wreg(hi, 8'h00);
  endtask
  // Source edges: two cycles high, two low, then settle
  task pulse(input [2:0] w, input integer c);
    repeat (c)
    begin
      src <= w;
      repeat (2) @(posedge clk);
      src <= 3'h0;
      repeat (2) @(posedge clk);
    end
    repeat (5) @(posedge clk);
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rchk(ctl, 32'h0);
    rchk(insel, 32'h0);
    wreg(16'h0100, 8'hff);
    rchk(16'h0100, 32'h0);
    rchk(ctl, 32'h0);
    for (i = 0; i < 4; i = i + 1)
    begin
      lfsr = nxt_rand(lfsr);
      wreg(insel, lfsr[7:0]);
      rchk(insel, {24'h0, lfsr[7:0]});
    end
    // Only the selected line may count
    wreg(ctl, 8'h40);
    for (i = 0; i < 4; i = i + 1)
    begin
      lfsr = nxt_rand(lfsr);
      n = lfsr[3:0] + 1;
      s = src_of(i[1:0]);
      wreg(insel, {2'h0, i[1:0], 4'h0});
      clr;
      pulse(s, n);
      pulse({s[1:0], s[2]}, 3);
      rchk(lo, n);
    end
    wreg(insel, 8'h00);
    clr;
    pulse(3'h1, 300);
    rchk(lo, 32'h2c);
    rchk(hi, 32'h1);
    clr;
    rchk(lo, 32'h0);
    rchk(hi, 32'h0);
    wreg(ctl, 8'h00);
    pulse(3'h1, 10);
    rchk(lo, 32'h0);
    wreg(ctl, 8'h40);
    pulse(3'h1, 3);
    wreg(ctl, 8'h00);
    pulse(3'h1, 5);
    rchk(lo, 32'h8);
    wreg(ctl, 8'h40);
    wreg(ctl, 8'h50);
    bus(1'b0, ctl, 8'h00);
    chk(q[3], 1'b1);
    wreg(ctl, 8'h40);
    clr;
    wreg(insel, 8'h30);
    hold <= 1'b1;
    pulse(3'h4, 5);
    rchk(lo, 32'h0);
    pwr <= 1'b1;
    pulse(3'h4, 5);
    rchk(lo, 32'h5);
    hold <= 1'b0;
    wreg(insel, 8'h00);
    // Enables off while the period select moves, so stray flags stay quiet
    for (i = 0; i < 8; i = i + 1)
    begin
      r = row(i);
      wreg(ctl, r[22:15] & 8'hfa);
      clr;
      wreg(ctl, r[22:15]);
      pulse(3'h1, r[14:0] - 1);
      chk(irq, 1'b0);
      pulse(3'h1, 1);
      chk(irq, 1'b1);
      chk(hrel, 1'b1);
    end
    pulse(3'h1, 10);
    chk(irq, 1'b1);
    wreg(ctl, 8'h41);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    pwm <= 1'b0;
    repeat (3) @(posedge clk);
    chk(buz, 1'b0);
    pwm <= 1'b1;
    pulse(3'h1, 20);
    chk(buz, 1'b1);
    wreg(insel, 8'h08);
    repeat (3) @(posedge clk);
    tog = 0;
    pulse(3'h1, 32);
    chk(tog, 4);
    give_verdict;
  end
endmodule // btm14_base_timer_tb
